// ---- ovf_pkg.sv ----
package ovf_pkg;
  localparam int unsigned RESP_MSB    = 7;
  localparam int unsigned RESP_LSB    = 6;
  localparam int unsigned RETRY_MSB   = 5;
  localparam int unsigned RETRY_LSB   = 3;
  localparam int unsigned DELAY_MSB   = 2;
  localparam int unsigned DELAY_LSB   = 0;
  localparam logic [7:0]  ACTION_RESET = 8'h80;
  localparam logic [1:0]  RESP_IGNORE  = 2'h0;
  localparam logic [1:0]  RESP_DELAY   = 2'h1;
  localparam logic [1:0]  RESP_RETRY   = 2'h2;
  localparam logic [1:0]  RESP_HOLD    = 2'h3;
  localparam logic [2:0]  RETRY_NONE   = 3'h0;
  localparam logic [2:0]  RETRY_ALWAYS = 3'h7;
  localparam logic [15:0] UNIT_CYCLES_DEFAULT = 16'h0064;

  typedef enum logic [6:0] {
    ST_RUN     = 7'h01,
    ST_DELAY   = 7'h02,
    ST_OFFWAIT = 7'h04,
    ST_TRY     = 7'h08,
    ST_LATCHED = 7'h10,
    ST_HOLD    = 7'h20,
    ST_CMDOFF  = 7'h40
  } ovf_state_t;
endpackage : ovf_pkg

// ---- ovf_unit_tick.sv ----
`timescale 1ns/1ps
module ovf_unit_tick #(
  parameter int unsigned CNT_W = 16
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             restart_in,
  input  wire logic [CNT_W-1:0] unit_cycles_in,
  output logic                  tick_out
);
  // Below two bits the end compare cannot tell one cycle from two
  if (CNT_W < 2)
  begin : g_bad_cnt_w
    $error("ovf_unit_tick: CNT_W too small");
  end

  logic [CNT_W-1:0] count;
  // Zero unit length behaves as one cycle
  wire logic        at_end = (count + 1'b1 >= unit_cycles_in);

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      count    <= '0;
      tick_out <= 1'b0;
    end
    else if (restart_in)
    begin
      count    <= '0;
      tick_out <= 1'b0;
    end
    else
    begin
      count    <= at_end ? '0 : count + 1'b1;
      tick_out <= at_end;
    end
  end
endmodule : ovf_unit_tick

// ---- ovf_fault_ctrl.sv ----
`timescale 1ns/1ps
module ovf_fault_ctrl #(
  parameter int unsigned UNIT_W = 16
) (
  input  wire logic              sys_clk_in,
  input  wire logic              resetn_in,
  input  wire logic              action_wr_in,
  input  wire logic [7:0]        action_data_in,
  input  wire logic [UNIT_W-1:0] delay_unit_cycles_in,
  input  wire logic              ov_detect_in,
  input  wire logic              fault_bit_clear_in,
  input  wire logic              clear_faults_in,
  input  wire logic              output_on_cmd_in,
  input  wire logic              bias_ok_in,
  input  wire logic              other_fault_in,
  output logic [7:0]             overvoltage_fault_action_out,
  output logic                   power_enable_out,
  output logic                   fault_latched_out,
  output logic [2:0]             attempts_out,
  output logic [6:0]             state_out
);
  if (UNIT_W < 2 || UNIT_W > 32)
  begin : g_bad_unit_w
    $error("ovf_fault_ctrl: UNIT_W out of range");
  end

  function automatic logic [7:0] units_of(input logic [2:0] code);
    units_of = 8'h01 << code;
  endfunction : units_of

  // Zero retries skips the wait and latches straight away
  function automatic ovf_pkg::ovf_state_t off_state_of(input logic [2:0] tries);
    off_state_of = (tries == ovf_pkg::RETRY_NONE) ? ovf_pkg::ST_LATCHED : ovf_pkg::ST_OFFWAIT;
  endfunction : off_state_of

  logic             rst_meta;
  logic             rst_sync_n;
  logic [7:0]       overvoltage_fault_action;
  ovf_pkg::ovf_state_t state;
  ovf_pkg::ovf_state_t next_state;
  logic [7:0]       unit_count;
  logic [2:0]       attempts;
  logic             fault_latched;
  logic             unit_tick;

  // Release taken on the clock so no flop sees a runt release
  always_ff @(posedge sys_clk_in or negedge resetn_in)
  begin
    if (!resetn_in)
    begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end
    else
    begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  wire logic [1:0] resp = overvoltage_fault_action[ovf_pkg::RESP_MSB:ovf_pkg::RESP_LSB];
  wire logic [2:0] retries = overvoltage_fault_action[ovf_pkg::RETRY_MSB:ovf_pkg::RETRY_LSB];
  wire logic [2:0] delay_code = overvoltage_fault_action[ovf_pkg::DELAY_MSB:ovf_pkg::DELAY_LSB];

  // Off command or bias loss wins over every state transition; an over-voltage still sets the fault flag
  wire logic cmd_off = !output_on_cmd_in || !bias_ok_in;
  wire logic user_clear = fault_bit_clear_in || clear_faults_in;
  wire logic delay_done = unit_tick && (unit_count == units_of(delay_code) - 8'h01);
  // Unlimited setting never runs out
  wire logic may_retry = (retries == ovf_pkg::RETRY_ALWAYS) || (attempts < retries);
  wire logic in_retry = (state == ovf_pkg::ST_OFFWAIT) || (state == ovf_pkg::ST_TRY);
  wire logic stop_retry = in_retry && other_fault_in;
  // Timer restarts only on entry; TRY back to OFFWAIT keeps it running
  wire logic enter_wait = (next_state == ovf_pkg::ST_OFFWAIT && state != ovf_pkg::ST_OFFWAIT
                           && state != ovf_pkg::ST_TRY)
                          || (next_state == ovf_pkg::ST_DELAY && state != ovf_pkg::ST_DELAY)
                          || (next_state == ovf_pkg::ST_TRY && state != ovf_pkg::ST_TRY);
  wire logic next_enable = (next_state == ovf_pkg::ST_RUN) || (next_state == ovf_pkg::ST_DELAY)
                           || (next_state == ovf_pkg::ST_TRY);

  // Off command checked last so it overrides every other transition
  always_comb
  begin
    next_state = state;
    unique case (state)
      ovf_pkg::ST_RUN:
      begin
        if (ov_detect_in)
        begin
          unique case (resp)
            ovf_pkg::RESP_IGNORE: next_state = ovf_pkg::ST_RUN;
            ovf_pkg::RESP_DELAY:  next_state = ovf_pkg::ST_DELAY;
            ovf_pkg::RESP_RETRY:  next_state = off_state_of(retries);
            ovf_pkg::RESP_HOLD:   next_state = ovf_pkg::ST_HOLD;
          endcase
        end
      end
      ovf_pkg::ST_DELAY:
      begin
        if (delay_done)
        begin
          if (!ov_detect_in)
            next_state = ovf_pkg::ST_RUN;
          else
            next_state = off_state_of(retries);
        end
      end
      ovf_pkg::ST_OFFWAIT:
      begin
        if (delay_done)
          next_state = may_retry ? ovf_pkg::ST_TRY : ovf_pkg::ST_LATCHED;
      end
      ovf_pkg::ST_TRY:
      begin
        // Timer keeps running so attempt starts stay one delay apart
        if (ov_detect_in)
          next_state = ovf_pkg::ST_OFFWAIT;
        else if (delay_done)
          next_state = ovf_pkg::ST_RUN;
      end
      ovf_pkg::ST_LATCHED:
      begin
        if (user_clear)
          next_state = ovf_pkg::ST_RUN;
      end
      ovf_pkg::ST_HOLD:
      begin
        if (!ov_detect_in)
          next_state = ovf_pkg::ST_RUN;
      end
      ovf_pkg::ST_CMDOFF:
      begin
        if (!cmd_off)
          next_state = ovf_pkg::ST_RUN;
      end
      default: next_state = ovf_pkg::ST_CMDOFF;
    endcase
    if (stop_retry)
      next_state = ovf_pkg::ST_LATCHED;
    if (cmd_off)
      next_state = ovf_pkg::ST_CMDOFF;
  end

  // One unit tick per delay_unit_cycles_in clocks
  ovf_unit_tick #(
    .CNT_W (UNIT_W)
  ) u_tick (
    .clk_in         (sys_clk_in),
    .rst_n_in       (rst_sync_n),
    .restart_in     (enter_wait),
    .unit_cycles_in (delay_unit_cycles_in),
    .tick_out       (unit_tick)
  );

  // Plain write strobe; address decode sits with the management link
  always_ff @(posedge sys_clk_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      overvoltage_fault_action <= ovf_pkg::ACTION_RESET;
    else if (action_wr_in)
      overvoltage_fault_action <= action_data_in;
  end

  always_ff @(posedge sys_clk_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      state      <= ovf_pkg::ST_CMDOFF;
      unit_count <= 8'h00;
    end
    else
    begin
      state <= next_state;
      if (enter_wait)
        unit_count <= 8'h00;
      else if (delay_done)
        unit_count <= 8'h00;
      else if (unit_tick)
        unit_count <= unit_count + 8'h01;
    end
  end

  // Saturates so unlimited retrying never wraps back to zero
  always_ff @(posedge sys_clk_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      attempts <= 3'h0;
    else if (next_state == ovf_pkg::ST_TRY && state == ovf_pkg::ST_OFFWAIT)
      attempts <= (attempts == 3'h7) ? attempts : attempts + 3'h1;
    else if (next_state == ovf_pkg::ST_RUN || next_state == ovf_pkg::ST_CMDOFF)
      attempts <= 3'h0;
  end

  // Set beats clear; off-then-on clears through the command-off state
  always_ff @(posedge sys_clk_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
      fault_latched <= 1'b0;
    else if (ov_detect_in)
      fault_latched <= 1'b1;
    else if (user_clear || cmd_off)
      fault_latched <= 1'b0;
  end

  always_ff @(posedge sys_clk_in or negedge rst_sync_n)
  begin
    if (!rst_sync_n)
    begin
      power_enable_out             <= 1'b0;
      fault_latched_out            <= 1'b0;
      overvoltage_fault_action_out <= ovf_pkg::ACTION_RESET;
      attempts_out                 <= 3'h0;
      state_out                    <= ovf_pkg::ST_CMDOFF;
    end
    else
    begin
      power_enable_out             <= next_enable;
      fault_latched_out            <= fault_latched;
      overvoltage_fault_action_out <= overvoltage_fault_action;
      attempts_out                 <= attempts;
      state_out                    <= state;
    end
  end
endmodule : ovf_fault_ctrl

// ---- ovf_stage_model.sv ----
`timescale 1ns/1ps
module ovf_stage_model (
  input  wire logic clk_in,
  input  wire logic enable_in,
  input  wire logic fault_in,
  input  wire logic stuck_in,
  output logic      ov_detect_out
);
  initial ov_detect_out = 1'b0;
  // Over-voltage needs a running stage unless an outside source holds it
  always @(posedge clk_in)
    ov_detect_out <= fault_in && (enable_in || stuck_in);
endmodule : ovf_stage_model

// ---- ovf_fault_ctrl_assertions.sv ----
`timescale 1ns/1ps
module ovf_chk (
  input wire logic       sys_clk_in,
  input wire logic       resetn_in,
  input wire logic       ov_detect_in,
  input wire logic       fault_bit_clear_in,
  input wire logic       clear_faults_in,
  input wire logic       output_on_cmd_in,
  input wire logic       bias_ok_in,
  input wire logic [7:0] overvoltage_fault_action_out,
  input wire logic       power_enable_out,
  input wire logic       fault_latched_out,
  input wire logic [2:0] attempts_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!resetn_in);
  wire logic       up  = output_on_cmd_in && bias_ok_in;
  wire logic       clr = fault_bit_clear_in || clear_faults_in;
  wire logic [1:0] rsp = overvoltage_fault_action_out[7:6];
  wire logic [2:0] rty = overvoltage_fault_action_out[5:3];
  wire logic       en  = power_enable_out;
  chk_ignore_runs: assert property (rsp == 2'h0 && en && up |=> en)
    else $error("enable lost in ignore mode");
  chk_delay_runs: assert property (rsp == 2'h1 && en && up && attempts_out == 3'h0
    && $rose(ov_detect_in) |=> en) else $error("enable lost in delay mode");
  chk_disable_fast: assert property (rsp[1] && en && up && ov_detect_in |-> ##[1:2] !en)
    else $error("enable not dropped");
  chk_hold_resume: assert property ((rsp == 2'h3 && up && !ov_detect_in) [*3]
    |-> ##[0:1] en) else $error("hold did not resume");
  chk_flag_sets: assert property ($rose(ov_detect_in) && up |-> ##[1:2] fault_latched_out)
    else $error("flag not set");
  chk_flag_clears: assert property (fault_latched_out && clr && !ov_detect_in
    && !$past(ov_detect_in) && !$past(ov_detect_in, 2) |-> ##[1:2] !fault_latched_out)
    else $error("flag not cleared");
  chk_off_clears: assert property ((!up && !ov_detect_in) [*3]
    |-> !en && attempts_out == 3'h0 && !fault_latched_out) else $error("off state wrong");
  chk_attempt_bound: assert property (rty != 3'h7 |-> attempts_out <= rty)
    else $error("too many attempts");
  cov_retry_out: cover property (attempts_out == 3'h2 && $fell(en));
  cov_latched: cover property ($rose(fault_latched_out));
  cov_hold_back: cover property (rsp == 2'h3 && $rose(en));
endmodule : ovf_chk
bind ovf_fault_ctrl ovf_chk u_chk (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
  .ov_detect_in(ov_detect_in), .fault_bit_clear_in(fault_bit_clear_in),
  .clear_faults_in(clear_faults_in), .output_on_cmd_in(output_on_cmd_in),
  .bias_ok_in(bias_ok_in), .overvoltage_fault_action_out(overvoltage_fault_action_out),
  .power_enable_out(power_enable_out), .fault_latched_out(fault_latched_out),
  .attempts_out(attempts_out));

// ---- tb_ovf_fault_ctrl.sv ----
`timescale 1ns/1ps
module tb_ovf_fault_ctrl;
  logic       clk = 1'b0, rstn = 1'b0, wr = 1'b0, clr = 1'b0, clra = 1'b0, oth = 1'b0;
  logic       on = 1'b1, bias = 1'b1, flt = 1'b0, stuck = 1'b0, ov, en, lat;
  logic [7:0] data = 8'h00, act;
  logic [2:0] att;
  logic [6:0] st;
  logic [15:0] unit = 16'h0004;
  int         n_fail = 0, checks_done = 0, rises, gap, last, cnt;
  always #5 clk = ~clk;
  ovf_stage_model stage (.clk_in(clk), .enable_in(en), .fault_in(flt), .stuck_in(stuck),
    .ov_detect_out(ov));
  ovf_fault_ctrl uut (.sys_clk_in(clk), .resetn_in(rstn), .action_wr_in(wr),
    .action_data_in(data), .delay_unit_cycles_in(unit), .ov_detect_in(ov),
    .fault_bit_clear_in(clr), .clear_faults_in(clra), .output_on_cmd_in(on),
    .bias_ok_in(bias), .other_fault_in(oth), .overvoltage_fault_action_out(act),
    .power_enable_out(en), .fault_latched_out(lat), .attempts_out(att), .state_out(st));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  task automatic wr_act(input logic [7:0] v);
    wr = 1'b1;
    data = v;
    cyc(1);
    wr = 1'b0;
    cyc(3);
    chk(act, v);
  endtask : wr_act
  task automatic watch(input int n);
    logic p;
    p = en;
    rises = 0;
    repeat (n)
    begin
      cyc(1);
      cnt++;
      if (en && !p)
      begin
        rises++;
        gap = cnt - last;
        last = cnt;
      end
      p = en;
    end
  endtask : watch
  task automatic t_reset;
    chk(act, 8'h80);
    chk(en, 1'b1);
    chk(lat, 1'b0);
    $display("reset test done");
  endtask : t_reset
  task automatic t_ignore;
    wr_act(8'h00);
    flt = 1'b1;
    cyc(20);
    chk(en, 1'b1);
    chk(lat, 1'b1);
    flt = 1'b0;
    cyc(3);
    clr = 1'b1;
    cyc(1);
    clr = 1'b0;
    cyc(3);
    chk(lat, 1'b0);
    $display("ignore test done");
  endtask : t_ignore
  task automatic t_delay;
    wr_act(8'h42);
    flt = 1'b1;
    cyc(10);
    chk(en, 1'b1);
    cyc(35);
    chk(en, 1'b0);
    flt = 1'b0;
    clra = 1'b1;
    cyc(1);
    clra = 1'b0;
    cyc(4);
    chk(en, 1'b1);
    unit = 16'h0002;
    wr_act(8'h42);
    flt = 1'b1;
    cyc(7);
    chk(en, 1'b1);
    cyc(7);
    chk(en, 1'b0);
    flt = 1'b0;
    clra = 1'b1;
    cyc(1);
    clra = 1'b0;
    cyc(4);
    unit = 16'h0004;
    chk(en, 1'b1);
    $display("delay test done");
  endtask : t_delay
  task automatic t_retry;
    wr_act(8'h92);
    flt = 1'b1;
    watch(90);
    chk(8'(rises), 8'h02);
    chk(gap >= 15 && gap <= 17, 1'b1);
    chk(att, 3'h2);
    chk(en, 1'b0);
    chk(st, ovf_pkg::ST_LATCHED);
    chk(lat, 1'b1);
    flt = 1'b0;
    on = 1'b0;
    cyc(4);
    chk(lat, 1'b0);
    on = 1'b1;
    cyc(6);
    chk(en, 1'b1);
    $display("retry test done");
  endtask : t_retry
  task automatic t_always;
    wr_act(8'hba);
    flt = 1'b1;
    watch(200);
    chk(rises > 7, 1'b1);
    oth = 1'b1;
    cyc(3);
    oth = 1'b0;
    watch(40);
    chk(8'(rises), 8'h00);
    chk(st, ovf_pkg::ST_LATCHED);
    flt = 1'b0;
    bias = 1'b0;
    cyc(4);
    chk(att, 3'h0);
    bias = 1'b1;
    cyc(6);
    $display("always test done");
  endtask : t_always
  task automatic t_hold;
    wr_act(8'hc0);
    stuck = 1'b1;
    flt = 1'b1;
    cyc(10);
    chk(en, 1'b0);
    chk(st, ovf_pkg::ST_HOLD);
    flt = 1'b0;
    cyc(5);
    chk(en, 1'b1);
    stuck = 1'b0;
    $display("hold test done");
  endtask : t_hold
  task automatic t_reset_mid;
    wr_act(8'h00);
    flt = 1'b1;
    cyc(4);
    flt = 1'b0;
    cyc(3);
    chk(lat, 1'b1);
    rstn = 1'b0;
    cyc(2);
    chk(en, 1'b0);
    chk(lat, 1'b0);
    rstn = 1'b1;
    cyc(6);
    chk(lat, 1'b0);
    chk(act, 8'h80);
    chk(en, 1'b1);
    $display("mid-run reset test done");
  endtask : t_reset_mid
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : final_report
  initial
  begin
    cyc(6);
    rstn = 1'b1;
    cyc(6);
    t_reset;
    t_ignore;
    t_delay;
    t_retry;
    t_always;
    t_hold;
    t_reset_mid;
    final_report;
  end
  initial
  begin
    #20000;
    n_fail++;
    final_report;
  end
endmodule : tb_ovf_fault_ctrl
